// ===== hw/vsafc_pkg.sv
// package: register map, field positions, reset values and timing constants
package vsafc_pkg;
    // register byte addresses on the wishbone bus
    localparam logic [3:0] VSAFC_ADDR_AFC_CONTROL = 4'h0;
    localparam logic [3:0] VSAFC_ADDR_HORIZ_THRESH = 4'h4;
    localparam logic [3:0] VSAFC_ADDR_VERT_THRESH = 4'h8;
    localparam logic [3:0] VSAFC_ADDR_FIELD_WINDOW = 4'hc;
    localparam logic [3:0] VSAFC_ADDR_SYNC_SEP_CTRL = 4'h0;
    // afc_control fields
    localparam int VSAFC_B_IRQ_EN = 7;
    localparam int VSAFC_B_IRQ_FLAG = 6;
    localparam int VSAFC_B_REF_SEL = 5;
    localparam int VSAFC_B_BLANK = 4;
    localparam int VSAFC_B_RSVD = 3;
    localparam int VSAFC_B_PHASE_RST = 2;
    localparam int VSAFC_B_DOT_SEL = 1;
    localparam int VSAFC_B_SLICE = 0;
    // sync_input_mode_register and sync_separation_control fields
    localparam int VSAFC_B_LOWPASS = 2;
    localparam int VSAFC_B_VCOMP = 4;
    localparam int VSAFC_B_FIELD = 0;
    // reset values
    localparam logic [7:0] VSAFC_RST_AFC_CONTROL = 8'h10;
    localparam logic [7:0] VSAFC_RST_HORIZ_THRESH = 8'he0;
    localparam logic [7:0] VSAFC_RST_VERT_THRESH = 8'h00;
    localparam logic [7:0] VSAFC_RST_FIELD_WINDOW = 8'hf0;
    localparam logic [7:0] VSAFC_HORIZ_UNUSED = 8'he0;
    localparam logic [7:0] VSAFC_FIELD_UNUSED = 8'hf0;
    // writable masks
    localparam logic [7:0] VSAFC_AFC_WMASK = 8'ha7;
    // counter step: 2/OSC at 100 MHz system clock
    localparam int VSAFC_STEP_DIV = 2;
    localparam logic [7:0] VSAFC_ZERO8 = 8'h00;
    // afc reference clock division ratios
    localparam logic [9:0] VSAFC_DIV_576 = 10'd576;
    localparam logic [9:0] VSAFC_DIV_448 = 10'd448;
    localparam int VSAFC_WIN_SHIFT = 5;
    // wishbone request carrier
    typedef struct packed {
        logic [3:0] adr;
        logic [7:0] dat;
        logic we;
        logic sel;
    } vsafc_req_t;
    // sync status carrier
    typedef struct packed {
        logic sep_h;
        logic sep_v;
        logic afc_h;
        logic vdet;
        logic field_win;
    } vsafc_sync_t;
endpackage

// ===== hw/vsafc_sepcnt.sv
// threshold counter that separates one pulse from composite sync
`timescale 1ns/1ps
module vsafc_sepcnt
    import vsafc_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control
    input wire logic step_i,
    input wire logic sync_i,
    input wire logic [7:0] thresh_i,
    // result
    output logic pulse_o
);
    logic [7:0] count;
    wire at_thresh = (count == thresh_i);
    wire at_zero = (count == VSAFC_ZERO8);
    wire logic [7:0] next_count = sync_i ?
        (at_thresh ? count : count + 8'h01) :
        (at_zero ? count : count - 8'h01);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count <= VSAFC_ZERO8;
            pulse_o <= 1'b0;
        end else if (step_i) begin
            count <= next_count;
            if (sync_i && at_thresh)
                pulse_o <= 1'b1;
            else if (!sync_i && at_zero)
                pulse_o <= 1'b0;
        end
    end
endmodule

// ===== hw/vsafc_top.sv
// sync separation and afc control block with wishbone register slave
//
// Contract
// (R1) afc_control is 8 bits and resets to 0x10.
// (R2) afc reference clock is 576 or 448 times line rate; derives afc_h.
// (R3) noise flag sets when noise counter equals noise level.
// (R4) noise flag clears by reading 1 then writing 0; writing 1 sets nothing.
// (R5) bit 7 gates noise interrupt request; resets to 0.
// (R6) bit 5 selects external (0) or internal (1) reference line sync.
// (R7) software turns display off before changing reference select.
// (R8) bit 3 reads 0 and ignores writes; bit 4 is blank.
// (R9) phase reset enable relocks afc output to reference on mismatch.
// (R10) bit 1 picks dot clock: afc reference or dedicated clock pin.
// (R11) bit 0 picks 16 or 32 bit slice width; resets 0.
// (R12) horizontal pulse rises at threshold with sync high, falls at zero.
// (R13) horizontal threshold resets to 0xe0, upper three bits ones.
// (R14) software picks threshold near 1.6 us or 3.2 us.
// (R15) vertical pulse rises at 8-bit threshold, clears at zero.
// (R16) software sets vertical threshold half a line after sync start.
// (R17) lowpass enable feeds vertical counter with sync OR horizontal pulse.
// (R18) complement enable takes vertical detect from complement counter.
// (R19) field window drops at divider match, returns after half line.
// (R20) vertical detect rise sets field flag from field window.
// (R21) software centres field window on the proper edge.
// (R22) field flag invalid while internal sync is the reference.
//
// Local design decisions: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
module vsafc_top
    import vsafc_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [0:0] wb_sel_i,
    input wire logic [7:0] wb_dat_i,
    output logic [7:0] wb_dat_o,
    output logic wb_ack_o,
    // sync inputs from pins
    input wire logic csync_i,
    input wire logic int_hsync_i,
    input wire logic dot_clk_pin_i,
    input wire logic vcomp_vdet_i,
    // noise counter side
    input wire logic [7:0] noise_count_i,
    input wire logic [7:0] noise_level_i,
    // mode inputs from neighbouring registers
    input wire logic lowpass_en_i,
    input wire logic vcomp_en_i,
    // outputs
    output logic noise_irq_o,
    output logic sep_h_o,
    output logic sep_v_o,
    output logic afc_h_o,
    output logic afc_ref_clk_o,
    output logic dot_clk_o,
    output logic slice_32_o,
    output logic field_odd_o,
    output logic field_valid_o
);
    // pin synchronisers
    logic [1:0] cs_sy, ih_sy, dp_sy, vc_sy;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cs_sy <= 2'b00;
            ih_sy <= 2'b00;
            dp_sy <= 2'b00;
            vc_sy <= 2'b00;
        end else begin
            cs_sy <= {cs_sy[0], csync_i};
            ih_sy <= {ih_sy[0], int_hsync_i};
            dp_sy <= {dp_sy[0], dot_clk_pin_i};
            vc_sy <= {vc_sy[0], vcomp_vdet_i};
        end
    end
    wire csync = cs_sy[1];
    wire int_h = ih_sy[1];
    wire dot_pin = dp_sy[1];
    wire vc_vdet = vc_sy[1];

    // registers
    logic [7:0] afc_control;
    logic [7:0] horiz_threshold_value;
    logic [7:0] vert_threshold_value;
    logic [7:0] field_window_value;
    logic flag_seen;
    logic odd_field_flag;

    // bus decode
    vsafc_req_t req;
    assign req = '{adr: wb_adr_i, dat: wb_dat_i, we: wb_we_i,
                   sel: wb_sel_i[0]};
    wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr = bus_req && req.we && req.sel;
    wire rd = bus_req && !req.we;
    wire sel_afc = (req.adr == VSAFC_ADDR_AFC_CONTROL);
    wire sel_hth = (req.adr == VSAFC_ADDR_HORIZ_THRESH);
    wire sel_vth = (req.adr == VSAFC_ADDR_VERT_THRESH);
    wire sel_fw = (req.adr == VSAFC_ADDR_FIELD_WINDOW);

    // noise flag events
    wire noise_hit = (noise_count_i == noise_level_i); // [R3]
    wire flag_clear = wr && sel_afc && flag_seen &&
                      !req.dat[VSAFC_B_IRQ_FLAG]; // [R4]
    wire flag_now = afc_control[VSAFC_B_IRQ_FLAG];
    wire next_flag = noise_hit || (flag_now && !flag_clear); // [R3] [R4]

    // afc_control write: reserved and blank keep their fixed values
    wire logic [7:0] afc_wr_val = (req.dat & VSAFC_AFC_WMASK &
        ~(8'h01 << VSAFC_B_IRQ_FLAG)) |
        (VSAFC_RST_AFC_CONTROL & ~VSAFC_AFC_WMASK); // [R8]
    wire logic [7:0] afc_keep = afc_wr_val &
        ~(8'h01 << VSAFC_B_IRQ_FLAG);

    wire logic [7:0] rd_mux = sel_afc ? afc_control : VSAFC_ZERO8;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            afc_control <= VSAFC_RST_AFC_CONTROL; // [R1]
            horiz_threshold_value <= VSAFC_RST_HORIZ_THRESH; // [R13]
            vert_threshold_value <= VSAFC_RST_VERT_THRESH;
            field_window_value <= VSAFC_RST_FIELD_WINDOW;
            flag_seen <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= VSAFC_ZERO8;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= rd ? rd_mux : VSAFC_ZERO8;
            if (wr && sel_afc)
                afc_control <= afc_keep |
                    ({7'h00, next_flag} << VSAFC_B_IRQ_FLAG);
            else
                afc_control[VSAFC_B_IRQ_FLAG] <= next_flag;
            if (wr && sel_hth)
                horiz_threshold_value <= req.dat | VSAFC_HORIZ_UNUSED;
            if (wr && sel_vth)
                vert_threshold_value <= req.dat;
            if (wr && sel_fw)
                field_window_value <= req.dat | VSAFC_FIELD_UNUSED;
            if (rd && sel_afc && flag_now)
                flag_seen <= 1'b1;
            else if (flag_clear || !flag_now)
                flag_seen <= 1'b0;
        end
    end

    // 2/OSC step enable
    logic step;
    always_ff @(posedge clk_i) begin
        if (rst_i)
            step <= 1'b0;
        else
            step <= !step;
    end

    // separation counters
    wire sep_h;
    wire sep_v;
    vsafc_sepcnt u_hsep (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .step_i(step),
        .sync_i(csync),
        .thresh_i(horiz_threshold_value & ~VSAFC_HORIZ_UNUSED),
        .pulse_o(sep_h)
    ); // [R12]
    wire v_in = lowpass_en_i ? (csync || sep_h) : csync; // [R17]
    vsafc_sepcnt u_vsep (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .step_i(step),
        .sync_i(v_in),
        .thresh_i(vert_threshold_value),
        .pulse_o(sep_v)
    ); // [R15]

    // afc reference: dividing counter per line
    wire ref_sel = afc_control[VSAFC_B_REF_SEL]; // [R6]
    wire ref_h = ref_sel ? int_h : sep_h;
    logic ref_h_d;
    logic [9:0] div_cnt;
    logic ref_clk;
    wire ref_rise = ref_h && !ref_h_d;
    wire logic [9:0] div_len = afc_control[VSAFC_B_SLICE] ?
        VSAFC_DIV_448 : VSAFC_DIV_576; // [R2]
    wire div_wrap = (div_cnt == div_len - 10'd1);
    wire phase_err = ref_rise && (div_cnt != 10'd0) &&
        afc_control[VSAFC_B_PHASE_RST]; // [R9]
    wire logic [9:0] half_len = {1'b0, div_len[9:1]};
    wire logic [9:0] win_start = {2'b00, field_window_value[3:0], 4'h0};
    wire logic [9:0] win_end = win_start + half_len;

    logic vdet_d;
    logic field_win;
    wire vdet = vcomp_en_i ? vc_vdet : sep_v; // [R18]
    wire vdet_rise = vdet && !vdet_d;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_h_d <= 1'b0;
            div_cnt <= 10'd0;
            ref_clk <= 1'b0;
            vdet_d <= 1'b0;
            field_win <= 1'b1;
            odd_field_flag <= 1'b0;
        end else begin
            ref_h_d <= ref_h;
            vdet_d <= vdet;
            ref_clk <= !ref_clk;
            if (phase_err || div_wrap)
                div_cnt <= 10'd0; // [R9]
            else if (ref_clk)
                div_cnt <= div_cnt + 10'd1; // [R2]
            if (div_cnt == win_start)
                field_win <= 1'b0; // [R19]
            else if (div_cnt == win_end)
                field_win <= 1'b1; // [R19]
            if (vdet_rise)
                odd_field_flag <= field_win; // [R20]
        end
    end

    // outputs registered
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            noise_irq_o <= 1'b0;
            sep_h_o <= 1'b0;
            sep_v_o <= 1'b0;
            afc_h_o <= 1'b0;
            afc_ref_clk_o <= 1'b0;
            dot_clk_o <= 1'b0;
            slice_32_o <= 1'b0;
            field_odd_o <= 1'b0;
            field_valid_o <= 1'b0;
        end else begin
            noise_irq_o <= afc_control[VSAFC_B_IRQ_EN] && flag_now; // [R5]
            sep_h_o <= sep_h;
            sep_v_o <= sep_v;
            afc_h_o <= (div_cnt < {3'b000, 7'h20}); // [R2]
            afc_ref_clk_o <= ref_clk;
            dot_clk_o <= afc_control[VSAFC_B_DOT_SEL] ?
                dot_pin : ref_clk; // [R10]
            slice_32_o <= afc_control[VSAFC_B_SLICE]; // [R11]
            field_odd_o <= odd_field_flag;
            field_valid_o <= !ref_sel; // [R22]
        end
    end
endmodule

// ===== tb/vsafc_chk.sv
// assertion checker bound to the sync separator top
`timescale 1ns/1ps
module vsafc_chk (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [7:0] wb_dat_o,
    input wire logic wb_ack_o,
    // sync side
    input wire logic csync_i,
    input wire logic sep_h_o,
    input wire logic sep_v_o,
    input wire logic afc_ref_clk_o,
    input wire logic slice_32_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [15:0] hist;
    logic [1:0] run;
    logic rd0;
    logic rdx;
    assign rd0 = wb_ack_o && !wb_we_i && wb_adr_i == 4'h0;
    assign rdx = wb_ack_o && !wb_we_i && wb_adr_i != 4'h0;
    always_ff @(posedge clk_i) begin
        hist <= {hist[14:0], csync_i};
        run <= rst_i ? 2'h0 : run + {1'b0, run != 2'h3};
    end
    property p_ack;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    property p_idle; !wb_ack_o |-> wb_dat_o == 8'h00; endproperty
    property p_ctl; rd0 |-> wb_dat_o[4:3] == 2'b10; endproperty
    property p_wo; rdx |-> wb_dat_o == 8'h00; endproperty
    property p_hrise; $rose(sep_h_o) |-> |hist; endproperty
    property p_hfall; $fell(sep_h_o) |-> !(&hist); endproperty
    property p_vrise; $rose(sep_v_o) |-> |hist; endproperty
    property p_ref;
        run == 2'h3 |-> afc_ref_clk_o != $past(afc_ref_clk_o);
    endproperty
    property p_slice;
        $changed(slice_32_o) |-> $past(wb_ack_o) || $past(wb_ack_o, 2);
    endproperty
    a_ack: assert property (p_ack) else $error("no ack");
    a_pulse: assert property (p_pulse) else $error("long ack");
    a_idle: assert property (p_idle) else $error("data off ack");
    a_ctl: assert property (p_ctl) else $error("fixed bits");
    a_wo: assert property (p_wo) else $error("wo read");
    a_hrise: assert property (p_hrise) else $error("h rise");
    a_hfall: assert property (p_hfall) else $error("h fall");
    a_vrise: assert property (p_vrise) else $error("v rise");
    a_ref: assert property (p_ref) else $error("ref clk");
    a_slice: assert property (p_slice) else $error("slice");
    c_wr: cover property (wb_ack_o && wb_we_i);
    c_h: cover property ($rose(sep_h_o));
    c_v: cover property ($rose(sep_v_o));
endmodule

// ===== tb/vsafc_src.sv
// composite sync source with normal and broad vertical lines
`timescale 1ns/1ps
module vsafc_src #(
    parameter int LINE = 128,
    parameter int HW = 24,
    parameter int BW = 100
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // broad pulse lines while high
    input wire logic vert_i,
    // sync outputs, high in sync
    output logic csync_o,
    output logic hsync_o
);
    int cnt;
    always_ff @(posedge clk_i) begin
        cnt <= (rst_i || cnt == LINE - 1) ? 0 : cnt + 1;
    end
    assign csync_o = cnt < (vert_i ? BW : HW);
    assign hsync_o = cnt < HW;
endmodule

// ===== tb/tb_top.sv
// testbench for the sync separator and afc control block
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin failures++; \
    $display("BAD %s exp %0h got %0h", n, e, s); end end
module tb_top;
    import vsafc_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [3:0] wb_adr_i = 4'h0;
    logic [0:0] wb_sel_i = 1'b1;
    logic [7:0] wb_dat_i = 8'h00;
    logic [7:0] noise_count_i = 8'h00;
    logic [7:0] noise_level_i = 8'h33;
    logic dot_clk_pin_i = 1'b0;
    logic vcomp_vdet_i = 1'b0;
    logic lowpass_en_i = 1'b0;
    logic vcomp_en_i = 1'b0;
    logic vert = 1'b0;
    logic [7:0] wb_dat_o, q, d;
    logic wb_ack_o, csync_i, int_hsync_i, noise_irq_o, sep_h_o, sep_v_o;
    logic afc_h_o, afc_ref_clk_o, dot_clk_o, slice_32_o, field_odd_o;
    logic field_valid_o, ph, pv;
    int failures = 0, n_tests = 0, cyc_n = 0, nh = 0, nv = 0, h0, v0;
    integer seed = 32'ha4c6db21;
    vsafc_top dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .csync_i,
        .int_hsync_i, .dot_clk_pin_i, .vcomp_vdet_i, .noise_count_i,
        .noise_level_i, .lowpass_en_i, .vcomp_en_i, .noise_irq_o, .sep_h_o,
        .sep_v_o, .afc_h_o, .afc_ref_clk_o, .dot_clk_o, .slice_32_o,
        .field_odd_o, .field_valid_o);
    vsafc_src src (.clk_i, .rst_i, .vert_i(vert), .csync_o(csync_i),
        .hsync_o(int_hsync_i));
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc_n++;
        if (sep_h_o === 1'b1 && ph === 1'b0) nh++;
        if (sep_v_o === 1'b1 && pv === 1'b0) nv++;
        ph = sep_h_o;
        pv = sep_v_o;
        dot_clk_pin_i <= $random(seed);
        vcomp_vdet_i <= cyc_n[8];
        if (cyc_n == 10000) begin
            failures++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [3:0] a,
        input logic [7:0] v);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= v;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        `CHK("reg", e, q)
    endtask
    task automatic nz();
        noise_count_i <= noise_level_i;
        @(posedge clk_i);
        noise_count_i <= 8'h00;
        repeat (2) @(posedge clk_i);
    endtask
    task automatic sep(input logic v, input logic lp, input int ev);
        vert <= v;
        lowpass_en_i <= lp;
        repeat (256) @(posedge clk_i);
        h0 = nh;
        v0 = nv;
        repeat (512) @(posedge clk_i);
        `CHK("separated_horiz_pulse", 4, nh - h0)
        `CHK("separated_vert_pulse", ev, nv - v0)
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(4'h0, 8'h10);
        `CHK("slice", 1'b0, slice_32_o)
        `CHK("valid", 1'b1, field_valid_o)
        rd(4'h4, 8'h00);
        rd(4'h2, 8'h00);
        wb(1'b1, 4'h0, 8'hff);
        rd(4'h0, 8'hb7);
        repeat (8) begin
            d = $random(seed);
            wb(1'b1, 4'h0, d); // display taken as off here
            rd(4'h0, (d & 8'ha7) | 8'h10);
            `CHK("slice", d[0], slice_32_o)
            `CHK("valid", ~d[5], field_valid_o)
        end
        wb(1'b1, 4'h0, 8'h80);
        nz();
        `CHK("irq", 1'b1, noise_irq_o)
        wb(1'b1, 4'h0, 8'h80);
        rd(4'h0, 8'hd0);
        wb(1'b1, 4'h0, 8'h80);
        rd(4'h0, 8'h90);
        `CHK("irq", 1'b0, noise_irq_o)
        wb(1'b1, 4'h0, 8'h00);
        nz();
        `CHK("irq", 1'b0, noise_irq_o)
        rd(4'h0, 8'h50);
        wb(1'b1, 4'h0, 8'hc0);
        @(posedge clk_i);
        `CHK("irq", 1'b1, noise_irq_o)
        wb(1'b1, 4'h4, 8'h04);
        wb(1'b1, 4'h8, 8'h28);
        wb(1'b1, 4'hc, 8'h04);
        sep(1'b0, 1'b0, 0);
        sep(1'b1, 1'b0, 0);
        `CHK("separated_vert_pulse_hi", 1'b1, sep_v_o)
        wb(1'b1, 4'h8, 8'h0e);
        vcomp_en_i <= 1'b1;
        sep(1'b0, 1'b0, 0);
        sep(1'b0, 1'b1, 4);
        stop_test();
    end
endmodule
bind vsafc_top vsafc_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .csync_i, .sep_h_o,
    .sep_v_o, .afc_ref_clk_o, .slice_32_o);
